// [verilog/tcr_cfg.svh]
// Purpose: constants of the rejection report framer
// Assumes: included by bare name after the package
// Notes: every field value, word slot and length lives here
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// primary header fields
`define TCR_VERSION 3'h0
`define TCR_TM_TYPE 1'h0
`define TCR_DFH_FLAG 1'h1
`define TCR_PID 7'h47
`define TCR_CAT_EVENT 4'h1
`define TCR_SEG_FLAGS 2'h3
`define TCR_CNT_W 14

// data field header fields
`define TCR_PUS_VER 3'h1
`define TCR_CKS_FLAG 1'h0
`define TCR_SPARE 4'h0
`define TCR_SVC_TYPE 8'h01
`define TCR_SVC_SUBTYPE 8'h02
`define TCR_PAD 8'h00

// failure codes and packet length fields (octets after header - 1)
`define TCR_FC_CKS 16'h0002
`define TCR_FC_PID 16'h0003
`define TCR_LEN_CKS 16'h0015
`define TCR_LEN_PID 16'h0011

// word slots inside a report, in send order
`define TCR_W_ID 4'h0
`define TCR_W_SEQ 4'h1
`define TCR_W_LEN 4'h2
`define TCR_W_T0 4'h3
`define TCR_W_T1 4'h4
`define TCR_W_T2 4'h5
`define TCR_W_DF0 4'h6
`define TCR_W_DF1 4'h7
`define TCR_W_GID 4'h8
`define TCR_W_SCW 4'h9
`define TCR_W_FC 4'ha
`define TCR_W_SVC 4'hb
`define TCR_W_RCK 4'hc
`define TCR_W_CCK 4'hd
`define TCR_W_STEP 4'h1

// beats per report, for the handshake count check
`define TCR_BEATS_CKS 5'h0e
`define TCR_BEATS_PID 5'h0c

`endif

// [verilog/tcr_pkg.sv]
// Purpose: types of the rejection report framer
// Assumes: nothing beyond the standard
// Notes: widths follow the report layout
package tcr_pkg;

  // framer states, gray along idle -> send
  typedef enum logic [1:0] {
    TCR_IDLE = 2'b00,
    TCR_SEND = 2'b01
  } tcr_state_e;

  // which acceptance fault is reported
  typedef enum logic {
    TCR_FAULT_CKS = 1'b0,
    TCR_FAULT_PID = 1'b1
  } tcr_fault_e;

  // fault request from the telecommand checker
  typedef struct packed {
    tcr_fault_e kind;
    logic [15:0] tc_seq_ctrl;    // seg flags and count of rejected tc
    logic [7:0] tc_svc_type;     // service type of rejected tc
    logic [7:0] tc_svc_subtype;  // service subtype of rejected tc
    logic [15:0] rx_cks;         // checksum carried by the tc
    logic [15:0] calc_cks;       // checksum computed locally
  } tcr_req_s;

  // one report held while it is sent
  typedef struct packed {
    tcr_req_s req;
    logic [47:0] acq_time;
    logic [13:0] seq_count;
  } tcr_rep_s;

  // all state of the framer but the sequence and beat counters
  typedef struct packed {
    tcr_state_e st;
    logic [3:0] idx;
    tcr_rep_s rep;
    logic [15:0] data;
    logic valid;
  } tcr_regs_s;

endpackage : tcr_pkg

// [verilog/tcr_seq_counter.sv]
// Purpose: source sequence counter for one pid/category pair
// Assumes: adv is a one-cycle pulse per emitted report
// Notes: wraps modulo 2**W like the header field
`timescale 1ns/100ps
module tcr_seq_counter #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic adv,
  output logic [W-1:0] count
);

  logic [W-1:0] count_ff; // value for the next report
  logic [W-1:0] nxt_count;

  // step by one per report, zero after reset
  always_comb begin
    nxt_count = count_ff;
    if (adv) begin
      nxt_count = count_ff + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

  seq_step_a: assert property (@(posedge clk) disable iff (rst)
    adv |=> count_ff == W'($past(count_ff) + W'(1)))
    else $error("sequence count did not step");

endmodule : tcr_seq_counter

// [verilog/tcr_framer.sv]
// Purpose: frame telecommand acceptance failure event reports
// Assumes: checker holds req stable while req_valid and not ready
// Notes: one report in flight; the checker stalls while it drains
`timescale 1ns/100ps
`include "tcr_cfg.svh"

// Function
// - report every telecommand with a foreign identifier
// - report every telecommand failing its checksum
// - fixed primary header, pid 71, event category
// - per pid/category counter, zero at start
// - acquisition time, seconds then fraction
// - data field header, type 1 subtype 2
// - checksum fault: six words, code 2
// - identifier fault: four words, code 3
// - service info holds rejected type, subtype
// - global id and sequence control composition
module tcr_framer import tcr_pkg::*; #(
  parameter int CNT_W = `TCR_CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input tcr_req_s req,
  input wire logic [47:0] now_time,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data,
  output logic out_first,
  output logic out_last
);

  // the header field is fixed at fourteen bits
  if (CNT_W != `TCR_CNT_W) begin : g_bad_width
    $error("tcr_framer: CNT_W must be 14");
  end

  tcr_regs_s state_ff;  // registered framer state
  tcr_regs_s nxt_state; // next value of it
  logic [CNT_W-1:0] seq_cnt; // count for the next report
  logic accept;         // fault request taken this cycle
  logic beat;           // output word taken this cycle
  logic [3:0] last_idx; // slot of the final word
  logic [4:0] hs_cnt_ff; // beats seen, read by checks only
  logic [4:0] nxt_hs_cnt;

  // build one word of the report from its held fields
  function automatic logic [15:0] word_at(tcr_rep_s r, logic [3:0] i);
    logic cks;
    cks = (r.req.kind == TCR_FAULT_CKS);
    case (i)
      `TCR_W_ID: word_at = {`TCR_VERSION, `TCR_TM_TYPE, `TCR_DFH_FLAG,
                            `TCR_PID, `TCR_CAT_EVENT};
      `TCR_W_SEQ: word_at = {`TCR_SEG_FLAGS, r.seq_count};
      `TCR_W_LEN: word_at = cks ? `TCR_LEN_CKS : `TCR_LEN_PID;
      `TCR_W_T0: word_at = r.acq_time[47:32];
      `TCR_W_T1: word_at = r.acq_time[31:16];
      `TCR_W_T2: word_at = r.acq_time[15:0];
      `TCR_W_DF0: word_at = {`TCR_PUS_VER, `TCR_CKS_FLAG, `TCR_SPARE,
                             `TCR_SVC_TYPE};
      `TCR_W_DF1: word_at = {`TCR_SVC_SUBTYPE, `TCR_PAD};
      `TCR_W_GID: word_at = {5'h00, `TCR_PID, `TCR_CAT_EVENT};
      `TCR_W_SCW: word_at = r.req.tc_seq_ctrl;
      `TCR_W_FC: word_at = cks ? `TCR_FC_CKS : `TCR_FC_PID;
      `TCR_W_SVC: word_at = {r.req.tc_svc_type,
                             r.req.tc_svc_subtype};
      `TCR_W_RCK: word_at = r.req.rx_cks;
      `TCR_W_CCK: word_at = r.req.calc_cks;
      default: word_at = 16'h0000;
    endcase
  endfunction : word_at

  // one counter serves the single pid/category pair this block emits
  tcr_seq_counter #(
    .W(CNT_W)
  ) u_seq_counter (
    .clk(clk),
    .rst(rst),
    .adv(accept),
    .count(seq_cnt)
  );

  // ready only when idle: a fault arriving mid-report waits at the port
  assign req_ready = (state_ff.st == TCR_IDLE);
  assign accept = req_valid && req_ready;
  assign beat = state_ff.valid && out_ready;
  // final slot differs: checksum reports carry two extra words
  assign last_idx = (state_ff.rep.req.kind == TCR_FAULT_CKS) ?
                    `TCR_W_CCK : `TCR_W_SVC;

  // next state: latch fault and time, then walk the word slots
  always_comb begin
    nxt_state = state_ff;
    case (state_ff.st)
      TCR_IDLE: begin
        if (req_valid) begin
          nxt_state.rep.req = req;
          nxt_state.rep.acq_time = now_time;
          nxt_state.rep.seq_count = seq_cnt;
          nxt_state.idx = `TCR_W_ID;
          nxt_state.data = word_at(nxt_state.rep, `TCR_W_ID);
          nxt_state.valid = 1'b1;
          nxt_state.st = TCR_SEND;
        end
      end
      TCR_SEND: begin
        if (out_ready && state_ff.idx == last_idx) begin
          // report done, back to waiting
          nxt_state.valid = 1'b0;
          nxt_state.idx = `TCR_W_ID;
          nxt_state.st = TCR_IDLE;
        end else if (out_ready) begin
          // next slot; data stays put while the sink stalls
          nxt_state.idx = state_ff.idx + `TCR_W_STEP;
          nxt_state.data = word_at(state_ff.rep, nxt_state.idx);
        end
      end
      default: begin
        nxt_state = '0;
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign out_valid = state_ff.valid;
  assign out_data = state_ff.data;
  assign out_first = state_ff.valid && (state_ff.idx == `TCR_W_ID);
  assign out_last = state_ff.valid && (state_ff.idx == last_idx);

  // beat counter for the length checks only
  always_comb begin
    nxt_hs_cnt = hs_cnt_ff;
    if (beat && out_last) begin
      nxt_hs_cnt = 5'h00;
    end else if (beat) begin
      nxt_hs_cnt = hs_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hs_cnt_ff <= 5'h00;
    end else begin
      hs_cnt_ff <= nxt_hs_cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fault_starts_report_a: assert property (
    accept |=> out_valid && out_first && out_data[10:4] == `TCR_PID)
    else $error("fault did not start a report");

  primary_hdr_a: assert property (out_first |-> out_data ==
    {`TCR_VERSION, `TCR_TM_TYPE, `TCR_DFH_FLAG, `TCR_PID, `TCR_CAT_EVENT})
    else $error("primary header word wrong");

  acq_time_a: assert property (
    accept |=> state_ff.rep.acq_time == $past(now_time))
    else $error("acquisition time not latched at fault");

  // checked per slot, so a stalled word does not look like a wrong one
  data_hdr_a: assert property (
    out_valid && (state_ff.idx == `TCR_W_DF0 || state_ff.idx == `TCR_W_DF1)
    |-> out_data == ((state_ff.idx == `TCR_W_DF0) ?
    {`TCR_PUS_VER, `TCR_CKS_FLAG, `TCR_SPARE, `TCR_SVC_TYPE} :
    {`TCR_SVC_SUBTYPE, `TCR_PAD}))
    else $error("data field header wrong");

  report_beats_a: assert property (out_valid && out_last |->
    hs_cnt_ff + 5'h01 == ((state_ff.rep.req.kind == TCR_FAULT_CKS) ?
    `TCR_BEATS_CKS : `TCR_BEATS_PID))
    else $error("report word count wrong");

  fail_code_a: assert property (
    out_valid && state_ff.idx == `TCR_W_FC |-> out_data ==
    ((state_ff.rep.req.kind == TCR_FAULT_CKS) ? `TCR_FC_CKS : `TCR_FC_PID))
    else $error("failure code wrong");

  svc_info_a: assert property (
    out_valid && state_ff.idx == `TCR_W_SVC |-> out_data ==
    {state_ff.rep.req.tc_svc_type, state_ff.rep.req.tc_svc_subtype})
    else $error("service info wrong");

  global_id_a: assert property (
    out_valid && state_ff.idx == `TCR_W_GID |->
    out_data == {5'h00, `TCR_PID, `TCR_CAT_EVENT})
    else $error("global identifier wrong");

  pkt_length_a: assert property (
    out_valid && state_ff.idx == `TCR_W_LEN |-> out_data ==
    ((state_ff.rep.req.kind == TCR_FAULT_CKS) ?
    `TCR_LEN_CKS : `TCR_LEN_PID))
    else $error("packet length wrong");

  stall_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(state_ff.idx))
    else $error("word changed under stall");

  cks_report_c: cover property (
    beat && out_last && state_ff.rep.req.kind == TCR_FAULT_CKS);
  pid_report_c: cover property (
    beat && out_last && state_ff.rep.req.kind == TCR_FAULT_PID);
  stall_c: cover property (out_valid && !out_ready [*3]);
  back_to_back_c: cover property (beat && out_last ##1 accept);

endmodule : tcr_framer

// [bench/tcr_tm_sink.sv]
// Purpose: telemetry downlink sink that takes report words
// Assumes: stall_en is set by the bench; ready moves at the falling edge
// Notes: random stalls vary the back pressure from word to word
`timescale 1ns/100ps
module tcr_tm_sink (
  input wire logic clk,
  input wire logic stall_en,
  output logic out_ready
);
  // ready after time zero, before the framer can present anything
  initial out_ready = 1'b1;

  // stalls about one cycle in three; the framer must then hold its word
  always @(negedge clk) begin
    out_ready <= !stall_en || ($urandom % 3 != 0);
  end
endmodule : tcr_tm_sink

// [bench/tb_tcr_framer.sv]
// Purpose: self-checking bench of the rejection report framer
// Assumes: inputs move at the falling edge; sink model gives out_ready
// Notes: the driver queues every expected word; a monitor pops and compares
`timescale 1ns/100ps
module tb_tcr_framer import tcr_pkg::*; ;
  logic clk = 1'b0;
  logic rst;
  logic req_valid;
  logic req_ready;
  tcr_req_s req;
  logic [47:0] now_time;
  logic out_valid, out_ready, out_first, out_last;
  logic [15:0] out_data;
  logic stall_en;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [17:0] exp_q[$]; // {first, last, word}
  logic [13:0] exp_cnt;  // expected sequence count

  always #5 clk = ~clk;

  tcr_framer i_tcr_framer (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .now_time(now_time),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_first(out_first), .out_last(out_last));

  tcr_tm_sink i_tcr_tm_sink (.clk(clk), .stall_en(stall_en),
    .out_ready(out_ready));

  // single place where the verdict is printed
  task automatic close_out();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [19:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  // present one fault, hold it until taken, then queue its whole report
  task automatic send(input tcr_req_s r, input logic [47:0] t);
    int k;
    int n;
    logic [15:0] w[14];
    n = (r.kind == TCR_FAULT_CKS) ? 14 : 12;
    @(negedge clk);
    req = r;
    now_time = t;
    req_valid = 1'b1;
    k = 0;
    // ready only moves at rising edges, so this value holds for the take
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    w = '{{3'h0, 1'h0, 1'h1, 7'd71, 4'd1}, {2'b11, exp_cnt},
      (n == 14) ? 16'd21 : 16'd17, t[47:32], t[31:16], t[15:0],
      {3'h1, 1'h0, 4'h0, 8'd1}, {8'd2, 8'h00}, {5'h0, 7'd71, 4'd1},
      r.tc_seq_ctrl, (n == 14) ? 16'd2 : 16'd3,
      {r.tc_svc_type, r.tc_svc_subtype}, r.rx_cks, r.calc_cks};
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({i == 0, i == n - 1, w[i]});
    end
    exp_cnt++;
    @(negedge clk);
    req_valid = 1'b0;
  endtask : send

  // wait, bounded, until every queued word has left
  task automatic drain();
    int k;
    k = 0;
    while ((exp_q.size() != 0 || out_valid !== 1'b0) && k < 600) begin
      @(negedge clk);
      k++;
    end
    chk("words left", 20'(exp_q.size()), 20'h0);
  endtask : drain

  // monitor: every taken word must be the oldest expected one
  always @(posedge clk) begin : mon
    logic [17:0] e;
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 18'h3ffff;
      chk("report word", {2'b00, out_first, out_last, out_data},
        {2'b00, e});
    end
  end

  // hang guard: all tests need far fewer cycles than this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h9753));
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    now_time = '0;
    stall_en = 1'b0;
    exp_cnt = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("idle outputs", {req_ready, out_valid, out_first, out_last,
      out_data}, 20'h80000);
    // boundary field values, both faults back to back, no stall
    send('{TCR_FAULT_CKS, 16'hffff, 8'hff, 8'h00, 16'h0000, 16'hffff},
      48'hffff_ffff_0001);
    send('{TCR_FAULT_PID, 16'h0000, 8'h00, 8'hff, 16'h1234, 16'h5678},
      48'h0000_0001_ffff);
    drain();
    $display("test directed done");
    // random faults under random sink stalls; the count keeps stepping
    stall_en = 1'b1;
    repeat (20) begin
      send('{tcr_fault_e'($urandom_range(1)), 16'($urandom), 8'($urandom),
        8'($urandom), 16'($urandom), 16'($urandom)},
        {16'($urandom), 32'($urandom)});
    end
    drain();
    $display("test random done");
    // reset in mid report: output stops and the count restarts at zero
    send('{TCR_FAULT_CKS, 16'h4001, 8'h11, 8'h22, 16'h3333, 16'h4444},
      48'h1);
    repeat (4) @(negedge clk);
    rst = 1'b1;
    exp_q.delete();
    @(negedge clk);
    rst = 1'b0;
    // the cut report must be gone and the port idle again
    chk("reset outputs", {req_ready, out_valid, out_first, out_last,
      out_data}, 20'h80000);
    exp_cnt = '0;
    send('{TCR_FAULT_PID, 16'hc005, 8'h06, 8'h07, 16'h0, 16'h0}, 48'h2);
    drain();
    $display("test reset done");
    close_out();
  end
endmodule : tb_tcr_framer
